/* fbp_params.svh */
// Constants for the flash block protection logic: geometry and policy encodings.
// Assumes byte addresses into the flash array starting at zero.
`ifndef FBP_PARAMS_SVH
`define FBP_PARAMS_SVH

// ==========================================================================
// Geometry
`define FBP_FLASH_BYTES 131072
`define FBP_ERASE_BYTES 1024
`define FBP_PAIR_BYTES 2048
`define FBP_ADDR_W 17
`define FBP_PAIR_CNT 64
`define FBP_PAIR_W 6
`define FBP_ERASED_WORD 32'hffffffff

// ==========================================================================
// Protection field positions in the per-pair setting
`define FBP_BIT_RO 0
`define FBP_BIT_XO 1

`endif

/* fbp_pkg.sv */
// Types shared by the flash block protection logic.
// Assumes fbp_params.svh is on the include path.
package fbp_pkg;

  // Kind of access a requester asks for
  typedef enum logic [2:0] {
    FBP_OP_FETCH,
    FBP_OP_DREAD,
    FBP_OP_DBG_READ,
    FBP_OP_PROGRAM,
    FBP_OP_ERASE
  } fbp_op_t;

  // Reason for refusal
  typedef enum logic [1:0] {
    FBP_ERR_NONE,
    FBP_ERR_RANGE,
    FBP_ERR_WRITE_PROT,
    FBP_ERR_READ_PROT
  } fbp_err_t;

endpackage : fbp_pkg

/* fbp_policy.sv */
// Pure access decision for one request against one pair's setting.
// Assumes the caller supplies the setting of the pair that holds the address.
`timescale 1ns/1ns
`include "fbp_params.svh"
module fbp_policy
(
  input wire fbp_pkg::fbp_op_t op,
  input wire logic in_range,
  input wire logic [1:0] prot,
  output fbp_pkg::fbp_err_t err
);

  // ==========================================================================
  // Decision
  // Range first, then write protection, then read protection
  always_comb
  begin
    err = fbp_pkg::FBP_ERR_NONE;
    if (!in_range)
      err = fbp_pkg::FBP_ERR_RANGE;
    else if ((op == fbp_pkg::FBP_OP_PROGRAM || op == fbp_pkg::FBP_OP_ERASE) &&
             (prot[`FBP_BIT_RO] || prot[`FBP_BIT_XO]))
      err = fbp_pkg::FBP_ERR_WRITE_PROT;
    else if (prot[`FBP_BIT_XO] && (op == fbp_pkg::FBP_OP_DREAD || op == fbp_pkg::FBP_OP_DBG_READ))
      err = fbp_pkg::FBP_ERR_READ_PROT;
  end

endmodule : fbp_policy

/* fbp_guard.sv */
// Flash block protection gate: checks each request and drives flash commands.
// Assumes one request per cycle from an arbiter on the same clock; the flash
// array answers erase/program/read commands and settings come from logic.
// Each request is answered exactly two edges after it is taken, refused or
// not, so answers leave in request order and need no tag.
// Limitation: no busy handshake; the arbiter must hold off while the array
// is still erasing or programming.
// prot_map is read in the cycle of the request, so a change of setting
// applies from the next request on.
//
// How it works
// - flash is 128 KB; out-of-range refused
// - erase touches one 1 KB unit only
// - erased unit reads back all ones
// - one setting per 2 KB pair
// - read-only pair refuses erase and program
// - execute-only pair refuses erase and program
// - execute-only pair serves instruction fetches only
`timescale 1ns/1ns
`include "fbp_params.svh"
module fbp_guard
#(
  parameter int ADDR_W = `FBP_ADDR_W,
  parameter int PAIR_CNT = `FBP_PAIR_CNT
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire fbp_pkg::fbp_op_t req_op,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic [2*PAIR_CNT-1:0] prot_map,
  input wire logic [31:0] flash_rdata,
  output logic resp_valid,
  output logic resp_fault,
  output fbp_pkg::fbp_err_t resp_err,
  output logic [31:0] resp_rdata,
  output logic flash_erase,
  output logic flash_prog,
  output logic flash_read,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [31:0] flash_wdata
);

  localparam int PAIR_W = $clog2(PAIR_CNT);

  // Pair index from a byte address
  function automatic logic [PAIR_W-1:0] pair_of(input logic [31:0] a);
    pair_of = a[ADDR_W-1 -: PAIR_W];
  endfunction : pair_of

  // First byte of the 1 KB erase unit holding an address
  function automatic logic [ADDR_W-1:0] unit_base(input logic [31:0] a);
    unit_base = a[ADDR_W-1:0] & ~ADDR_W'(`FBP_ERASE_BYTES - 1);
  endfunction : unit_base

  // Operations that hand flash contents back to a requester
  function automatic logic is_read_op(input fbp_pkg::fbp_op_t op);
    is_read_op = (op == fbp_pkg::FBP_OP_FETCH) || (op == fbp_pkg::FBP_OP_DREAD) ||
      (op == fbp_pkg::FBP_OP_DBG_READ);
  endfunction : is_read_op

  // ==========================================================================
  // Request decode
  logic in_range;
  logic [1:0] prot;
  fbp_pkg::fbp_err_t err;
  logic grant;

  // Full-width compare, so addresses above the array never alias into it
  assign in_range = (req_addr < 32'(`FBP_FLASH_BYTES));
  assign prot = prot_map[2*pair_of(req_addr) +: 2];

  // Verdict for this request against its pair's setting
  fbp_policy u_policy
  (
    .op(req_op),
    .in_range(in_range),
    .prot(prot),
    .err(err)
  );

  // Only a clean verdict lets a command reach the array
  assign grant = req_valid && (err == fbp_pkg::FBP_ERR_NONE);

  // ==========================================================================
  // Stage 1: command to the flash array
  logic cmd_erase_nxt;
  logic cmd_prog_nxt;
  logic cmd_read_nxt;
  logic [ADDR_W-1:0] addr_nxt;
  logic [31:0] wdata_nxt;

  // Flash strobes only when allowed, so refusals never disturb contents
  always_comb
  begin
    cmd_erase_nxt = 1'b0;
    cmd_prog_nxt = 1'b0;
    cmd_read_nxt = 1'b0;
    addr_nxt = flash_addr;
    wdata_nxt = flash_wdata;
    if (grant)
    begin
      addr_nxt = req_addr[ADDR_W-1:0];
      unique case (req_op)
        fbp_pkg::FBP_OP_ERASE:
        begin
          cmd_erase_nxt = 1'b1;
          // Align to 1 KB unit so neighbours are untouched
          addr_nxt = unit_base(req_addr);
        end
        fbp_pkg::FBP_OP_PROGRAM:
        begin
          cmd_prog_nxt = 1'b1;
          wdata_nxt = req_wdata;
        end
        // All three read kinds share one strobe
        fbp_pkg::FBP_OP_FETCH, fbp_pkg::FBP_OP_DREAD, fbp_pkg::FBP_OP_DBG_READ:
        begin
          cmd_read_nxt = is_read_op(req_op);
        end
        default:
        begin
          cmd_read_nxt = 1'b0;
        end
      endcase
    end
  end

  // Command registers; address and data hold between granted requests
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      flash_erase <= 1'b0;
      flash_prog <= 1'b0;
      flash_read <= 1'b0;
      flash_addr <= '0;
      flash_wdata <= 32'h00000000;
    end
    else
    begin
      flash_erase <= cmd_erase_nxt;
      flash_prog <= cmd_prog_nxt;
      flash_read <= cmd_read_nxt;
      flash_addr <= addr_nxt;
      flash_wdata <= wdata_nxt;
    end
  end

  // ==========================================================================
  // Stage 1: verdict kept for the answer
  logic pend_r;
  logic pend_nxt;
  fbp_pkg::fbp_err_t pend_err_r;
  fbp_pkg::fbp_err_t pend_err_nxt;
  logic pend_read_r;
  logic pend_read_nxt;

  // Every request is answered, refused or not, to keep answers in order
  always_comb
  begin
    pend_nxt = req_valid;
    pend_err_nxt = req_valid ? err : fbp_pkg::FBP_ERR_NONE;
    pend_read_nxt = grant && is_read_op(req_op);
  end

  // Verdict registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pend_r <= 1'b0;
      pend_err_r <= fbp_pkg::FBP_ERR_NONE;
      pend_read_r <= 1'b0;
    end
    else
    begin
      pend_r <= pend_nxt;
      pend_err_r <= pend_err_nxt;
      pend_read_r <= pend_read_nxt;
    end
  end

  // ==========================================================================
  // Stage 2: answer to the requester
  logic resp_valid_nxt;
  logic resp_fault_nxt;
  fbp_pkg::fbp_err_t resp_err_nxt;
  logic [31:0] resp_rdata_nxt;

  // Answer one cycle after the flash command; blocked reads return zero
  always_comb
  begin
    resp_valid_nxt = pend_r;
    resp_fault_nxt = pend_r && (pend_err_r != fbp_pkg::FBP_ERR_NONE);
    resp_err_nxt = pend_r ? pend_err_r : fbp_pkg::FBP_ERR_NONE;
    resp_rdata_nxt = (pend_r && pend_read_r) ? flash_rdata : 32'h00000000;
  end

  // Answer registers; every field stands for one cycle only
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      resp_valid <= 1'b0;
      resp_fault <= 1'b0;
      resp_err <= fbp_pkg::FBP_ERR_NONE;
      resp_rdata <= 32'h00000000;
    end
    else
    begin
      resp_valid <= resp_valid_nxt;
      resp_fault <= resp_fault_nxt;
      resp_err <= resp_err_nxt;
      resp_rdata <= resp_rdata_nxt;
    end
  end

endmodule : fbp_guard

/* fbp_guard_monitor.sv */
// Checker bound onto fbp_guard: access policy at its ports.
// Assumes the two-cycle answer of the guard.
`timescale 1ns/1ns
module fbp_guard_monitor
#(
  parameter int ADDR_W = 17,
  parameter int PAIR_CNT = 64
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire fbp_pkg::fbp_op_t req_op,
  input wire logic [31:0] req_addr,
  input wire logic [2*PAIR_CNT-1:0] prot_map,
  input wire logic [31:0] flash_rdata,
  input wire logic resp_valid,
  input wire logic resp_fault,
  input wire fbp_pkg::fbp_err_t resp_err,
  input wire logic [31:0] resp_rdata,
  input wire logic flash_erase,
  input wire logic flash_prog,
  input wire logic flash_read,
  input wire logic [ADDR_W-1:0] flash_addr
);
  // ==========
  // Decode of the request
  logic [1:0] pr;
  logic oor, wr, rd, bad;
  logic [16:0] a_r;
  assign pr = prot_map[{req_addr[16:11], 1'b0} +: 2];
  assign oor = req_addr > 32'h1ffff;
  assign wr = req_op >= fbp_pkg::FBP_OP_PROGRAM;
  assign rd = req_op inside {fbp_pkg::FBP_OP_DREAD, fbp_pkg::FBP_OP_DBG_READ};
  assign bad = oor | wr & (pr != 2'h0) | rd & pr[1];
  // Address kept for the alignment check
  always_ff @(posedge sys_clk) a_r <= req_addr[16:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========
  // Properties
  AST_RANGE: assert property (req_valid & oor |-> ##2 resp_err == fbp_pkg::FBP_ERR_RANGE)
    else $error("range not refused");
  AST_ERASE_UNIT: assert property (req_valid & !bad & req_op == fbp_pkg::FBP_OP_ERASE |=> flash_erase && flash_addr == {a_r[16:10], 10'h0})
    else $error("erase unit wrong");
  AST_RO_LOCK: assert property (req_valid & !oor & wr & pr == 2'h1 |=> !flash_prog & !flash_erase ##1 resp_err == fbp_pkg::FBP_ERR_WRITE_PROT)
    else $error("read-only written");
  AST_XO_LOCK: assert property (req_valid & !oor & wr & pr[1] |-> ##2 resp_fault & resp_err == fbp_pkg::FBP_ERR_WRITE_PROT)
    else $error("exec-only written");
  AST_XO_READ: assert property (req_valid & !oor & rd & pr[1] |-> ##2 resp_err == fbp_pkg::FBP_ERR_READ_PROT && resp_rdata == 32'h0)
    else $error("exec-only read");
  AST_READ_OK: assert property (req_valid & !bad & !wr |=> flash_read ##1 resp_valid & !resp_fault)
    else $error("read refused");
  AST_REFUSE: assert property (req_valid & bad |=> !(flash_erase | flash_prog | flash_read) ##1 resp_valid & resp_fault)
    else $error("refusal leaked");
  AST_RDATA: assert property (flash_read |=> resp_valid && resp_rdata == $past(flash_rdata))
    else $error("read data lost");
  C_ERASE: cover property (req_valid & !bad & req_op == fbp_pkg::FBP_OP_ERASE);
  C_XO_RD: cover property (req_valid & rd & pr[1]);
  C_OOR: cover property (req_valid & oor);
endmodule : fbp_guard_monitor
bind fbp_guard fbp_guard_monitor #(.ADDR_W(ADDR_W), .PAIR_CNT(PAIR_CNT)) fbp_guard_monitor_inst (.sys_clk, .rst,
  .req_valid, .req_op, .req_addr, .prot_map, .flash_rdata, .resp_valid, .resp_fault, .resp_err, .resp_rdata,
  .flash_erase, .flash_prog, .flash_read, .flash_addr);

/* fbp_flash_model.sv */
// Behavioural flash array behind the guard's commands.
// Assumes reads are served while the read strobe is high.
`timescale 1ns/1ns
module fbp_flash_model
(
  input wire logic sys_clk,
  input wire logic flash_erase,
  input wire logic flash_prog,
  input wire logic flash_read,
  input wire logic [16:0] flash_addr,
  input wire logic [31:0] flash_wdata,
  output logic [31:0] flash_rdata
);
  // ==========
  // Storage preloaded with each word's index
  logic [31:0] mem [32768];
  logic [31:0] junk = 32'h0f0f0f0f;
  initial for (int i = 0; i < 32768; i++) mem[i] = i;
  // Junk outside reads, so stale data never looks valid
  assign flash_rdata = flash_read ? mem[flash_addr[16:2]] : junk;
  // Erase clears the whole 1 KB unit
  always @(posedge sys_clk)
  begin
    junk <= ~junk;
    if (flash_erase)
      for (int i = 0; i < 256; i++) mem[{flash_addr[16:10], 8'h0} + i] = 32'hffffffff;
    if (flash_prog)
      mem[flash_addr[16:2]] = flash_wdata;
  end
endmodule : fbp_flash_model

/* fbp_guard_tb.sv */
// Self-checking bench for fbp_guard with a flash model.
// Assumes each answer comes two cycles after its request.
`timescale 1ns/1ns
module fbp_guard_tb;
  logic sys_clk, rst, req_valid, resp_valid, resp_fault, flash_erase, flash_prog, flash_read;
  fbp_pkg::fbp_op_t req_op;
  fbp_pkg::fbp_err_t resp_err, qe[$];
  logic [31:0] req_addr, req_wdata, flash_rdata, resp_rdata, flash_wdata, sh[int], qd[$];
  logic [127:0] prot_map;
  logic [16:0] flash_addr;
  int miscompares, num_checks;
  fbp_guard #(.ADDR_W(17), .PAIR_CNT(64)) fbp_guard_inst (.sys_clk, .rst, .req_valid, .req_op, .req_addr,
    .req_wdata, .prot_map, .flash_rdata, .resp_valid, .resp_fault, .resp_err, .resp_rdata, .flash_erase,
    .flash_prog, .flash_read, .flash_addr, .flash_wdata);
  fbp_flash_model fbp_flash_model_inst (.sys_clk, .flash_erase, .flash_prog, .flash_read, .flash_addr,
    .flash_wdata, .flash_rdata);
  // ==========
  // Clock, checks and closing
  always #25 sys_clk = ~sys_clk;
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task chk_err(input fbp_pkg::fbp_err_t e);
    num_checks++;
    if (resp_err !== e || resp_fault !== (e != fbp_pkg::FBP_ERR_NONE))
    begin
      miscompares++;
      $display("MISMATCH resp_err exp %0d got %0d", e, resp_err);
    end
  endtask : chk_err
  task chk_data(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH data exp %h got %h", e, g);
    end
  endtask : chk_data
  function automatic fbp_pkg::fbp_err_t exp_err(input fbp_pkg::fbp_op_t o, input logic [31:0] a);
    logic [1:0] p;
    p = prot_map[{a[16:11], 1'b0} +: 2];
    if (a > 32'h1ffff) return fbp_pkg::FBP_ERR_RANGE;
    if (o >= fbp_pkg::FBP_OP_PROGRAM) return p != 2'h0 ? fbp_pkg::FBP_ERR_WRITE_PROT : fbp_pkg::FBP_ERR_NONE;
    if (o != fbp_pkg::FBP_OP_FETCH && p[1]) return fbp_pkg::FBP_ERR_READ_PROT;
    return fbp_pkg::FBP_ERR_NONE;
  endfunction : exp_err
  // One request for one cycle; shadow tracks only allowed changes
  task rq(input fbp_pkg::fbp_op_t o, input logic [31:0] a);
    fbp_pkg::fbp_err_t e;
    logic [31:0] d;
    e = exp_err(o, a);
    d = sh.exists(a[16:2]) ? sh[a[16:2]] : {17'h0, a[16:2]};
    req_valid = 1'b1;
    req_op = o;
    req_addr = a;
    req_wdata = $urandom;
    if (e == fbp_pkg::FBP_ERR_NONE && o == fbp_pkg::FBP_OP_ERASE)
      for (int i = 0; i < 256; i++) sh[{a[16:10], 8'h0} + i] = 32'hffffffff;
    if (e == fbp_pkg::FBP_ERR_NONE && o == fbp_pkg::FBP_OP_PROGRAM) sh[a[16:2]] = req_wdata;
    qe.push_back(e);
    qd.push_back(e == fbp_pkg::FBP_ERR_NONE && o < fbp_pkg::FBP_OP_PROGRAM ? d : 32'h0);
    @(posedge sys_clk);
    #5;
  endtask : rq
  // Answers in order, one per request
  always @(posedge sys_clk)
    if (resp_valid === 1'b1)
    begin
      chk_err(qe.pop_front());
      chk_data(qd.pop_front(), resp_rdata);
    end
  // Watchdog against a hang
  initial
  begin
    #1000000;
    miscompares++;
    end_sim();
  end
  // Corner cases on pairs 0..3 (free, read-only, exec-only, both), then random
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = fbp_pkg::FBP_OP_FETCH;
    req_addr = 32'h0;
    req_wdata = 32'h0;
    void'($urandom(32'hf40c226a));
    prot_map = {$urandom, $urandom, $urandom, 24'h0, 8'he4};
    repeat (16) @(posedge sys_clk);
    #5;
    rst = 1'b0;
    for (int p = 0; p < 4; p++)
      for (int o = 4; o >= 0; o--) rq(fbp_pkg::fbp_op_t'(o), p * 2048 + 1028);
    rq(fbp_pkg::FBP_OP_DREAD, 32'h0);
    rq(fbp_pkg::FBP_OP_DREAD, 32'h400);
    rq(fbp_pkg::FBP_OP_ERASE, 32'h20000);
    rq(fbp_pkg::FBP_OP_FETCH, 32'h1fffc);
    repeat (300) rq(fbp_pkg::fbp_op_t'($urandom % 5), $urandom % 32'h20400);
    req_valid = 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_data(32'h0, qd.size());
    end_sim();
  end
endmodule : fbp_guard_tb
